/* verilog/panic_aggregator.sv */
/*
 * Error aggregator top: APB register file, suppress masks, master flag,
 * first-error code and a level interrupt.
 * Assumes error inputs are one-cycle or level signals on pclk, active high.
 */
`timescale 1ns/100ps
`default_nettype none

module panic_aggregator
    import panic_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Error sources
    input wire logic [11:0] parity_err,
    input wire logic soft_err,
    input wire logic wd_err,
    input wire logic stack_err,
    input wire logic loop_err,
    // Status outputs
    output logic panic_flag,
    output logic irq
);

    generate
        if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W must be between 18 and 32");
        end
    endgenerate

    panic_err_if eb ();

    panic_gate u_gate (
        .eb(eb)
    );

    panic_logger u_logger (
        .pclk(pclk),
        .presetn(presetn),
        .eb(eb)
    );

    logic [15:0] parity_sup_ff;
    logic [15:0] soft_sup_ff;
    logic [15:0] wd_sup_ff;
    logic [15:0] stack_sup_ff;
    logic [15:0] loop_sup_ff;
    logic [15:0] clear_ff;
    logic [IRQ_N-1:0] irq_status_ff;
    logic [IRQ_N-1:0] irq_enable_ff;
    logic [31:0] prdata_ff;
    logic [IRQ_N-1:0] nxt_irq_status;

    // Word index width; indices are zero-extended for wider address buses
    localparam int IDX_W = ADDR_W - ADDR_LSB;

    // Address decode
    wire [IDX_W-1:0] word_idx = paddr[ADDR_W-1:ADDR_LSB];
    wire aligned = (paddr[ADDR_LSB-1:0] == 2'b00);
    wire hit_clear = aligned && (word_idx == IDX_W'(IDX_CLEAR));
    wire hit_parity = aligned && (word_idx == IDX_W'(IDX_PARITY_SUP));
    wire hit_soft = aligned && (word_idx == IDX_W'(IDX_SOFT_SUP));
    wire hit_wd = aligned && (word_idx == IDX_W'(IDX_WD_SUP));
    wire hit_stack = aligned && (word_idx == IDX_W'(IDX_STACK_SUP));
    wire hit_loop = aligned && (word_idx == IDX_W'(IDX_LOOP_SUP));
    wire hit_master = aligned && (word_idx == IDX_W'(IDX_MASTER));
    wire hit_code = aligned && (word_idx == IDX_W'(IDX_CODE));
    wire hit_istat = aligned && (word_idx == IDX_W'(IDX_IRQ_STATUS));
    wire hit_iclr = aligned && (word_idx == IDX_W'(IDX_IRQ_CLEAR));
    wire hit_ien = aligned && (word_idx == IDX_W'(IDX_IRQ_ENABLE));
    wire hit_any = hit_clear | hit_parity | hit_soft | hit_wd | hit_stack | hit_loop
                 | hit_master | hit_code | hit_istat | hit_iclr | hit_ien;

    // Read data is latched in the setup cycle, so every access with clk_en high takes one wait-free access phase
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr_en = access & pwrite & hit_any & clk_en;

    // Byte-lane merge for the 16-bit registers
    wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [15:0] m);
        merge16 = (old_v & ~m) | (new_v & m);
    endfunction

    wire [15:0] wdata16 = pwdata[15:0];

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        case (1'b1)
            hit_clear: rd_mux = clear_ff;
            hit_parity: rd_mux = parity_sup_ff;
            hit_soft: rd_mux = soft_sup_ff;
            hit_wd: rd_mux = wd_sup_ff;
            hit_stack: rd_mux = stack_sup_ff;
            hit_loop: rd_mux = loop_sup_ff;
            hit_master: rd_mux = {15'h0000, eb.flag};
            hit_code: rd_mux = eb.code;
            hit_istat: rd_mux = {{(16-IRQ_N){1'b0}}, irq_status_ff};
            hit_ien: rd_mux = {{(16-IRQ_N){1'b0}}, irq_enable_ff};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Suppress registers; all 16 bits writable, reserved bits reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_sup_ff <= RST_PARITY_SUP;
            soft_sup_ff <= RST_SINGLE_SUP;
            wd_sup_ff <= RST_SINGLE_SUP;
            stack_sup_ff <= RST_SINGLE_SUP;
            loop_sup_ff <= RST_SINGLE_SUP;
            clear_ff <= RST_CLEAR;
        end else if (wr_en) begin
            if (hit_parity) begin
                parity_sup_ff <= merge16(parity_sup_ff, wdata16, lane_mask);
            end
            if (hit_soft) begin
                soft_sup_ff <= merge16(soft_sup_ff, wdata16, lane_mask);
            end
            if (hit_wd) begin
                wd_sup_ff <= merge16(wd_sup_ff, wdata16, lane_mask);
            end
            if (hit_stack) begin
                stack_sup_ff <= merge16(stack_sup_ff, wdata16, lane_mask);
            end
            if (hit_loop) begin
                loop_sup_ff <= merge16(loop_sup_ff, wdata16, lane_mask);
            end
            if (hit_clear) begin
                clear_ff <= merge16(clear_ff, wdata16, lane_mask);
            end
        end
    end

    // Source vector in code-register order
    assign eb.ce = clk_en;
    assign eb.raw_err = {soft_err, loop_err, stack_err, wd_err, parity_err};
    assign eb.suppress = {soft_sup_ff[SUP_BIT], loop_sup_ff[SUP_BIT], stack_sup_ff[SUP_BIT],
                          wd_sup_ff[SUP_BIT], parity_sup_ff[SRC_PARITY_HI:0]};
    assign eb.clear_level = clear_ff[CLEAR_BIT];

    // Interrupt status: a new event wins over a simultaneous clear
    wire [IRQ_N-1:0] irq_evt = {eb.later_evt, eb.logged_evt};
    wire [IRQ_N-1:0] irq_clr = (wr_en && hit_iclr && pstrb[0]) ? pwdata[IRQ_N-1:0] : {IRQ_N{1'b0}};
    assign nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= {IRQ_N{1'b0}};
            irq_enable_ff <= RST_IRQ_ENABLE;
        end else if (clk_en) begin
            irq_status_ff <= nxt_irq_status;
            if (wr_en && hit_ien && pstrb[0]) begin
                irq_enable_ff <= pwdata[IRQ_N-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en && setup) begin
            prdata_ff <= {16'h0000, rd_mux};
        end
    end

    // APB answer; a frozen block holds the access phase
    assign pready = clk_en;
    assign pslverr = access & ~hit_any;
    assign prdata = prdata_ff;

    assign panic_flag = eb.flag;
    assign irq = |(irq_status_ff & irq_enable_ff);

endmodule

`default_nettype wire

/* verilog/panic_pkg.sv */
/*
 * Shared constants of the error aggregator: register indices, field positions,
 * reset values and the layout of the source vector.
 * Assumes a 32-bit APB with word-aligned registers at byte address 4 * index.
 */
package panic_pkg;

    localparam int REG_W = 16;
    localparam int SRC_N = 16;
    localparam int ADDR_LSB = 2;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CLEAR = 16'hf421;
    localparam logic [15:0] IDX_PARITY_SUP = 16'hf422;
    localparam logic [15:0] IDX_SOFT_SUP = 16'hf423;
    localparam logic [15:0] IDX_WD_SUP = 16'hf424;
    localparam logic [15:0] IDX_STACK_SUP = 16'hf425;
    localparam logic [15:0] IDX_LOOP_SUP = 16'hf426;
    localparam logic [15:0] IDX_MASTER = 16'hf427;
    localparam logic [15:0] IDX_CODE = 16'hf428;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hf450;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'hf451;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hf452;

    // Reset values
    localparam logic [15:0] RST_PARITY_SUP = 16'h0003;
    localparam logic [15:0] RST_SINGLE_SUP = 16'h0000;
    localparam logic [15:0] RST_CLEAR = 16'h0000;
    localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

    // Source bit positions in the error vector and the code register
    localparam int SRC_SOFT = 15;
    localparam int SRC_LOOP = 14;
    localparam int SRC_STACK = 13;
    localparam int SRC_WD = 12;
    localparam int SRC_PARITY_HI = 11;

    // Single-bit suppress field and the clear trigger bit
    localparam int SUP_BIT = 0;
    localparam int CLEAR_BIT = 0;

    // Interrupt status bits
    localparam int IRQ_N = 2;
    localparam int IRQ_LOGGED = 0;
    localparam int IRQ_LATER = 1;

endpackage

/* verilog/panic_err_if.sv */
/*
 * Bundle between the register front end, the suppress gate and the logger.
 * Assumes all three sit on the same clock; the bundle itself holds no state.
 */
`timescale 1ns/100ps
`default_nettype none

interface panic_err_if;
    logic ce;
    logic [15:0] raw_err;
    logic [15:0] suppress;
    logic [15:0] reported;
    logic clear_level;
    logic flag;
    logic [15:0] code;
    logic logged_evt;
    logic later_evt;

    modport gate (input raw_err, input suppress, output reported);
    modport logger (input ce, input reported, input clear_level,
                    output flag, output code, output logged_evt, output later_evt);
    modport front (output ce, output raw_err, output suppress, output clear_level,
                   input reported, input flag, input code, input logged_evt, input later_evt);
endinterface

`default_nettype wire

/* verilog/panic_gate.sv */
/*
 * Per-source suppress gate: each raw error passes only while its suppress bit is 0.
 * Assumes raw errors come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module panic_gate
    import panic_pkg::*;
(
    // Bundle
    panic_err_if.gate eb
);

    // Gating before the OR, so a suppressed error is never remembered
    genvar i;
    generate
        for (i = 0; i < SRC_N; i++) begin : g_src
            assign eb.reported[i] = eb.raw_err[i] & ~eb.suppress[i];
        end
    endgenerate

endmodule

`default_nettype wire

/* verilog/panic_logger.sv */
/*
 * Sticky master flag and first-error code, cleared by a rising edge of the clear bit.
 * Assumes reported errors are already gated and on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module panic_logger
    import panic_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bundle
    panic_err_if.logger eb
);

    logic flag_ff;
    logic [15:0] code_ff;
    logic clear_prev_ff;
    logic nxt_flag;
    logic [15:0] nxt_code;

    wire any_err = |eb.reported;
    wire clear_rise = eb.clear_level & ~clear_prev_ff;
    wire flag_open = ~flag_ff | clear_rise;

    // A new error in the clearing cycle wins and is logged at once
    assign nxt_flag = any_err ? 1'b1 : (clear_rise ? 1'b0 : flag_ff);
    assign nxt_code = (any_err && flag_open) ? eb.reported : (clear_rise ? 16'h0000 : code_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
            code_ff <= 16'h0000;
            clear_prev_ff <= 1'b0;
        end else if (eb.ce) begin
            flag_ff <= nxt_flag;
            code_ff <= nxt_code;
            clear_prev_ff <= eb.clear_level;
        end
    end

    assign eb.flag = flag_ff;
    assign eb.code = code_ff;
    assign eb.logged_evt = eb.ce & any_err & flag_open;
    assign eb.later_evt = eb.ce & any_err & ~flag_open;

endmodule

`default_nettype wire

/* tb/panic_aggregator_assertions.sv */
/* Port checker of the error aggregator.
   Assumes pstrb is all ones on every write. */
`timescale 1ns/100ps
`default_nettype none
module panic_aggregator_assertions
    import panic_pkg::*;
#(parameter int ADDR_W = 18)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Errors and flag
    input wire logic [11:0] parity_err,
    input wire logic soft_err,
    input wire logic wd_err,
    input wire logic stack_err,
    input wire logic loop_err,
    input wire logic panic_flag
);
    logic [15:0] sup_ff;
    logic [15:0] err;
    logic wr;
    logic clr_set;
    function automatic logic [ADDR_W-1:0] a(input logic [15:0] i);
        return ADDR_W'({i, 2'b00});
    endfunction
    assign wr = psel && penable && pwrite && pready;
    assign err = {soft_err, loop_err, stack_err, wd_err, parity_err};
    assign clr_set = wr && paddr == a(IDX_CLEAR) && pwdata[0];
    // Mirror of the suppress bits, in source order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_ff <= {4'h0, RST_PARITY_SUP[11:0]};
        end else if (wr) begin
            if (paddr == a(IDX_PARITY_SUP)) sup_ff[11:0] <= pwdata[11:0];
            if (paddr == a(IDX_WD_SUP)) sup_ff[12] <= pwdata[0];
            if (paddr == a(IDX_STACK_SUP)) sup_ff[13] <= pwdata[0];
            if (paddr == a(IDX_LOOP_SUP)) sup_ff[14] <= pwdata[0];
            if (paddr == a(IDX_SOFT_SUP)) sup_ff[15] <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_follows_a: assert property (pready == clk_en) else $error("pready differs from clk_en");
    slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    unaligned_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access without pslverr");
    upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    flag_read_a: assert property (psel && penable && !pwrite && paddr == a(IDX_MASTER)
        |-> prdata == {31'h0, $past(panic_flag)}) else $error("master register read wrong");
    err_sets_a: assert property (clk_en && |(err & ~sup_ff) |=> panic_flag) else $error("error did not set flag");
    no_false_a: assert property (!panic_flag && !(|(err & ~sup_ff)) |=> !panic_flag)
        else $error("flag set by suppressed source");
    flag_hold_a: assert property (panic_flag && !$past(clr_set) |=> panic_flag) else $error("flag dropped");
    clear_drop_a: assert property ($fell(panic_flag) |-> $past(clr_set, 2)) else $error("flag fell untimely");
    cover property ($rose(panic_flag));
    cover property ($fell(panic_flag));
    cover property (pslverr);
endmodule
bind panic_aggregator panic_aggregator_assertions #(.ADDR_W(ADDR_W)) i_panic_aggregator_assertions (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .parity_err, .soft_err, .wd_err,
    .stack_err, .loop_err, .panic_flag);
`default_nettype wire

/* tb/tb_panic_aggregator.sv */
/* Self-checking bench of the error aggregator.
   Assumes clk_en drops only while the bus is idle, so every access has no wait state. */
`timescale 1ns/100ps
`default_nettype none
module tb_panic_aggregator
    import panic_pkg::*;
;
    logic pclk = 0;
    logic presetn = 0;
    logic clk_en = 1'b1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [15:0] ev = '0;
    logic [31:0] prdata;
    logic pready, pslverr, panic_flag, irq, se;
    logic [31:0] rd;
    logic [31:0] seed = 32'hf111;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #2 pclk = ~pclk;
    panic_aggregator i_panic_aggregator (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .parity_err(ev[11:0]), .soft_err(ev[15]), .wd_err(ev[12]),
        .stack_err(ev[13]), .loop_err(ev[14]), .panic_flag, .irq);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Register holding the suppress bit of source i
    function automatic logic [15:0] sup_idx(input int i);
        return i < 12 ? IDX_PARITY_SUP : i == SRC_WD ? IDX_WD_SUP : i == SRC_STACK ? IDX_STACK_SUP :
            i == SRC_LOOP ? IDX_LOOP_SUP : IDX_SOFT_SUP;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        xfer(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        xfer(1'b0, {idx, 2'b00}, 16'h0);
        chk(what, exp, rd);
    endtask
    // Error pulse; the flag has landed when this returns
    task automatic pulse(input logic [15:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= 16'h0;
        #1;
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("parity sup", IDX_PARITY_SUP, 32'h3);
        for (int i = 12; i < 16; i++) rchk("single sup", sup_idx(i), 32'h0);
        rchk("master", IDX_MASTER, 32'h0);
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            wr(16'(IDX_PARITY_SUP + k), seed[15:0]);
            rchk("mask rw", 16'(IDX_PARITY_SUP + k), {16'h0, seed[15:0]});
        end
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 5; k++) wr(16'(IDX_PARITY_SUP + k), 16'hffff);
            pulse(16'h1 << i);
            chk("suppressed", 32'h0, 32'(panic_flag));
            wr(sup_idx(i), i < 12 ? 16'hffff ^ (16'h1 << i) : 16'h0);
            // A held error would show one edge after the unmask
            @(posedge pclk);
            #1;
            chk("not remembered", 32'h0, 32'(panic_flag));
            seed = lfsr(seed);
            // Only source i is open, so random company must not show
            pulse(seed[15:0] | (16'h1 << i));
            chk("flag set", 32'h1, 32'(panic_flag));
            rchk("code", IDX_CODE, 32'h1 << i);
            wr(IDX_PARITY_SUP, 16'h0);
            pulse(16'hffff);
            chk("flag held", 32'h1, 32'(panic_flag));
            rchk("code held", IDX_CODE, 32'h1 << i);
            wr(IDX_CLEAR, 16'h1);
            wr(IDX_CLEAR, 16'h0);
            #1;
            chk("flag clr", 32'h0, 32'(panic_flag));
            rchk("code clr", IDX_CODE, 32'h0);
        end
        // Frozen block must not take an open error
        clk_en <= 1'b0;
        pulse(16'h0010);
        chk("frozen", 32'h0, 32'(panic_flag));
        @(posedge pclk);
        clk_en <= 1'b1;
        pulse(16'h0010);
        wr(IDX_MASTER, 16'h0);
        rchk("master ro", IDX_MASTER, 32'h1);
        wr(IDX_IRQ_ENABLE, 16'h0);
        #1;
        chk("irq masked", 32'h0, 32'(irq));
        wr(IDX_IRQ_ENABLE, 16'h3);
        #1;
        chk("irq on", 32'h1, 32'(irq));
        wr(IDX_IRQ_CLEAR, 16'h3);
        #1;
        chk("irq clr", 32'h0, 32'(irq));
        pulse(16'h0020);
        chk("irq later", 32'h1, 32'(irq));
        rchk("irq status", IDX_IRQ_STATUS, 32'h2);
        xfer(1'b0, 18'h00010, 16'h0);
        chk("unmapped err", 32'h1, 32'(se));
        chk("unmapped data", 32'h0, rd);
        tally_and_finish();
    end
endmodule
`default_nettype wire
